// >>> rtl/rme_pkg.sv
// Constants, register map and types for the reference memory editor
package rme_pkg;
    localparam int          RME_DEPTH       = 16384;
    localparam int          RME_AW          = 14;
    localparam int          RME_CH          = 32;
    localparam logic [13:0] RME_TOP_LARGE   = 14'h3FFF;
    localparam logic [13:0] RME_TOP_SMALL   = 14'h03FF;
    localparam logic [15:0] RME_TRIG_MIN_RT = 16'h0001;
    localparam logic [31:0] RME_CSUM_SMALL  = 32'h000FFFFF;

    // Register byte offsets
    localparam logic [7:0] RME_OFF_CTRL     = 8'h00;
    localparam logic [7:0] RME_OFF_CMD      = 8'h04;
    localparam logic [7:0] RME_OFF_CONFIRM  = 8'h08;
    localparam logic [7:0] RME_OFF_ADDR     = 8'h0C;
    localparam logic [7:0] RME_OFF_TRIG     = 8'h10;
    localparam logic [7:0] RME_OFF_CURSOR   = 8'h14;
    localparam logic [7:0] RME_OFF_ENTRY    = 8'h18;
    localparam logic [7:0] RME_OFF_STATUS   = 8'h1C;
    localparam logic [7:0] RME_OFF_CSUM     = 8'h20;

    // Field positions
    localparam int RME_CTRL_SMALL = 0;
    localparam int RME_CTRL_MODE  = 1;
    localparam int RME_CTRL_RT    = 3;
    localparam int RME_CMD_SRC    = 8;
    localparam int RME_CMD_DST    = 16;
    localparam int RME_ADDR_SEL   = 16;
    localparam int RME_CUR_BIT    = 16;

    // Reset values
    localparam logic [3:0]  RME_RST_CTRL = 4'h0;
    localparam logic [15:0] RME_RST_TRIG = 16'h0000;

    // Commands
    localparam logic [3:0] RME_OP_NONE   = 4'h0;
    localparam logic [3:0] RME_OP_CHMASK = 4'h1;
    localparam logic [3:0] RME_OP_COPY   = 4'h2;
    localparam logic [3:0] RME_OP_INS    = 4'h3;
    localparam logic [3:0] RME_OP_DEL    = 4'h4;
    localparam logic [3:0] RME_OP_RDN    = 4'h5;
    localparam logic [3:0] RME_OP_RUP    = 4'h6;
    localparam logic [3:0] RME_OP_SUM    = 4'h7;
    localparam logic [3:0] RME_OP_EXIT   = 4'h8;

    // Address entry targets
    localparam logic [2:0] RME_SEL_TOP = 3'h0;
    localparam logic [2:0] RME_SEL_INS = 3'h1;
    localparam logic [2:0] RME_SEL_DEL = 3'h2;
    localparam logic [2:0] RME_SEL_RDN = 3'h3;
    localparam logic [2:0] RME_SEL_RUP = 3'h4;

    typedef enum logic [1:0] {
        RME_MODE_HOLD  = 2'h0,
        RME_MODE_HORIZ = 2'h1,
        RME_MODE_VERT  = 2'h2
    } rme_mode_t;

    typedef enum logic [6:0] {
        RME_ST_IDLE   = 7'h01,
        RME_ST_CHMASK = 7'h02,
        RME_ST_COPY   = 7'h04,
        RME_ST_INS    = 7'h08,
        RME_ST_DEL    = 7'h10,
        RME_ST_REV    = 7'h20,
        RME_ST_SUM    = 7'h40
    } rme_state_t;

    typedef struct packed {
        logic        wmask;
        logic [31:0] bmask;
        logic [31:0] data;
    } rme_word_t;
endpackage

// >>> rtl/rme_editor.sv
// Reference memory bulk-edit engine with APB register access
// Functional notes
// - Set-channel-mask marks channel at every address; small mode marks only addresses 0 to 0x3FF
// - Copy one channel to another, others untouched
// - Copy only on confirm; exiting changes nothing
// - Insert zero word, shift later words up
// - Insert discards the word at top address
// - Delete removes word, shifts later words down
// - Delete writes zero word at top address
// - Roll down moves address zero to N
// - Roll up moves address N to zero
// - Rolls are circular, no word lost
// - Out-of-range address entry flags range error
// - Page exit restores last valid address
// - Checksum reported, eight or five digits
// - Checksum depends on every stored bit in large mode only; small mode keeps the low 20 sum bits
// - Hold mode keeps cursor in place
// - Horizontal mode steps right, wraps next line
// - Vertical mode steps to next address
// - Trigger delay at least one in compare
// - Masked bits and words never flag errors
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
module rme_editor
    import rme_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_valid,
    input  wire logic [13:0] cmp_addr,
    input  wire logic [31:0] cmp_data,
    output logic             cmp_error,
    output logic             entry_range_error,
    output logic             busy
);
    rme_word_t   mem [RME_DEPTH];
    rme_state_t  state_ff;
    logic [3:0]  ctrl_ff;
    logic [3:0]  pend_op_ff;
    logic [4:0]  src_ff;
    logic [4:0]  dst_ff;
    logic [13:0] valid_ff [5];
    logic [13:0] entered_ff;
    logic [2:0]  sel_ff;
    logic        err_ff;
    logic [15:0] trig_ff;
    logic [13:0] cur_addr_ff;
    logic [4:0]  cur_bit_ff;
    logic [13:0] i_ff;
    logic [13:0] lo_ff;
    logic [13:0] hi_ff;
    logic [13:0] amt_ff;
    logic [1:0]  phase_ff;
    logic        roll_up_ff;
    logic [31:0] sum_ff;
    logic [31:0] csum_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        cmp_error_ff;

    logic        acc;
    logic        wr_fire;
    logic [13:0] top;
    logic        idle;
    logic        start;
    logic        entry_wr;
    rme_word_t   cmp_ref;
    logic [31:0] nxt_sum;

    // Range of one reversal pass; three passes make a rotation
    function automatic logic [27:0] rev_range(input logic up, input logic [1:0] p,
                                              input logic [13:0] n, input logic [13:0] t);
        logic [13:0] nm1;
        logic [1:0]  q;
        nm1 = (n == 14'h0000) ? 14'h0000 : n - 14'h0001;
        q   = up ? ((p == 2'h2) ? 2'h0 : p + 2'h1) : p;
        case (q)
            2'h0:    rev_range = {14'h0000, t};
            2'h1:    rev_range = {14'h0000, nm1};
            default: rev_range = {n, t};
        endcase
    endfunction

    function automatic logic addr_ok(input logic [13:0] v, input logic [13:0] t);
        addr_ok = (v <= t);
    endfunction

    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign prdata            = prdata_ff;
    assign cmp_error         = cmp_error_ff;
    assign entry_range_error = err_ff;
    assign busy              = (state_ff != RME_ST_IDLE);

    assign top      = ctrl_ff[RME_CTRL_SMALL] ? RME_TOP_SMALL : RME_TOP_LARGE;
    assign idle     = (state_ff == RME_ST_IDLE);
    // One wait state: data is prepared in the first access cycle
    assign acc      = psel & penable & ~pready_ff;
    assign wr_fire  = psel & penable & pwrite & pready_ff;
    assign start    = wr_fire & (paddr == RME_OFF_CONFIRM) & idle & ~err_ff
                      & (pend_op_ff != RME_OP_NONE);
    assign entry_wr = wr_fire & (paddr == RME_OFF_ENTRY) & idle;
    assign cmp_ref  = mem[cmp_addr];
    assign nxt_sum  = {sum_ff[30:0], sum_ff[31]}
                      + (mem[i_ff].data ^ {mem[i_ff].bmask[15:0], mem[i_ff].bmask[31:16]})
                      + {31'h00000000, mem[i_ff].wmask};

    // APB slave answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff <= acc;
            if (acc) begin
                pslverr_ff <= (paddr > RME_OFF_CSUM) || (paddr[1:0] != 2'h0);
                prdata_ff  <= 32'h00000000;
                if (!pwrite) begin
                    case (paddr)
                        RME_OFF_CTRL:   prdata_ff <= {28'h0000000, ctrl_ff};
                        RME_OFF_CMD:    prdata_ff <= {11'h000, dst_ff, 3'h0, src_ff,
                                                      4'h0, pend_op_ff};
                        RME_OFF_ADDR:   prdata_ff <= {13'h0000, sel_ff, 2'h0,
                                                      err_ff ? entered_ff : valid_ff[sel_ff]};
                        RME_OFF_TRIG:   prdata_ff <= {16'h0000, trig_ff};
                        RME_OFF_CURSOR: prdata_ff <= {11'h000, cur_bit_ff, 2'h0, cur_addr_ff};
                        RME_OFF_STATUS: prdata_ff <= {29'h00000000, pend_op_ff != RME_OP_NONE,
                                                      err_ff, ~idle};
                        RME_OFF_CSUM:   prdata_ff <= csum_ff;
                        default:        prdata_ff <= 32'h00000000;
                    endcase
                end
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Control, trigger delay and pending command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= RME_RST_CTRL;
            trig_ff    <= RME_RST_TRIG;
            pend_op_ff <= RME_OP_NONE;
            src_ff     <= 5'h00;
            dst_ff     <= 5'h00;
        end else begin
            if (wr_fire && paddr == RME_OFF_CTRL) begin
                ctrl_ff <= pwdata[3:0];
                if (pwdata[RME_CTRL_RT] && trig_ff == 16'h0000)
                    trig_ff <= RME_TRIG_MIN_RT;
            end
            if (wr_fire && paddr == RME_OFF_TRIG) begin
                if (!(ctrl_ff[RME_CTRL_RT] && pwdata[15:0] == 16'h0000))
                    trig_ff <= pwdata[15:0];
            end
            if (wr_fire && paddr == RME_OFF_CMD && idle) begin
                // Bulk edits wait for confirm; exit drops them unexecuted
                if (pwdata[3:0] == RME_OP_EXIT || pwdata[3:0] == RME_OP_SUM)
                    pend_op_ff <= RME_OP_NONE;
                else
                    pend_op_ff <= pwdata[3:0];
                src_ff <= pwdata[RME_CMD_SRC +: 5];
                dst_ff <= pwdata[RME_CMD_DST +: 5];
            end else if (start) begin
                pend_op_ff <= RME_OP_NONE;
            end
        end
    end

    // Address entries with range check and restore on exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 5; k++)
                valid_ff[k] <= 14'h0000;
            entered_ff <= 14'h0000;
            sel_ff     <= RME_SEL_TOP;
            err_ff     <= 1'b0;
        end else begin
            if (wr_fire && paddr == RME_OFF_ADDR && idle && pwdata[18:16] <= RME_SEL_RUP) begin
                sel_ff     <= pwdata[RME_ADDR_SEL +: 3];
                entered_ff <= pwdata[13:0];
                // Target field sits inside 18:16, so only the bits around it must be clear
                if (addr_ok(pwdata[13:0], top) && pwdata[31:19] == 13'h0000
                    && pwdata[15:14] == 2'h0) begin
                    valid_ff[pwdata[RME_ADDR_SEL +: 3]] <= pwdata[13:0];
                    err_ff <= 1'b0;
                end else begin
                    err_ff <= 1'b1;
                end
            end else if (wr_fire && paddr == RME_OFF_TRIG && ctrl_ff[RME_CTRL_RT]
                         && pwdata[15:0] == 16'h0000) begin
                err_ff <= 1'b1;
            end else if (wr_fire && paddr == RME_OFF_CMD && pwdata[3:0] == RME_OP_EXIT) begin
                err_ff <= 1'b0;
            end else if (wr_fire && paddr == RME_OFF_CTRL && !addr_ok(valid_ff[sel_ff],
                         pwdata[RME_CTRL_SMALL] ? RME_TOP_SMALL : RME_TOP_LARGE)) begin
                for (int k = 0; k < 5; k++)
                    valid_ff[k] <= 14'h0000;
            end
        end
    end

    // Edit engine sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= RME_ST_IDLE;
            i_ff       <= 14'h0000;
            lo_ff      <= 14'h0000;
            hi_ff      <= 14'h0000;
            amt_ff     <= 14'h0000;
            phase_ff   <= 2'h0;
            roll_up_ff <= 1'b0;
            sum_ff     <= 32'h00000000;
            csum_ff    <= 32'h00000000;
        end else begin
            case (state_ff)
                RME_ST_IDLE: begin
                    if (wr_fire && paddr == RME_OFF_CMD && pwdata[3:0] == RME_OP_SUM) begin
                        state_ff <= RME_ST_SUM;
                        i_ff     <= 14'h0000;
                        sum_ff   <= 32'h00000000;
                    end else if (start) begin
                        phase_ff <= 2'h0;
                        case (pend_op_ff)
                            RME_OP_CHMASK: begin
                                state_ff <= RME_ST_CHMASK;
                                i_ff     <= 14'h0000;
                            end
                            RME_OP_COPY: begin
                                state_ff <= RME_ST_COPY;
                                i_ff     <= 14'h0000;
                            end
                            RME_OP_INS: begin
                                state_ff <= RME_ST_INS;
                                i_ff     <= top;
                                amt_ff   <= valid_ff[RME_SEL_INS];
                            end
                            RME_OP_DEL: begin
                                state_ff <= RME_ST_DEL;
                                i_ff     <= valid_ff[RME_SEL_DEL];
                            end
                            RME_OP_RDN, RME_OP_RUP: begin
                                state_ff   <= RME_ST_REV;
                                roll_up_ff <= (pend_op_ff == RME_OP_RUP);
                                amt_ff     <= (pend_op_ff == RME_OP_RUP)
                                              ? valid_ff[RME_SEL_RUP] : valid_ff[RME_SEL_RDN];
                                {lo_ff, hi_ff} <= rev_range(pend_op_ff == RME_OP_RUP, 2'h0,
                                    (pend_op_ff == RME_OP_RUP) ? valid_ff[RME_SEL_RUP]
                                                               : valid_ff[RME_SEL_RDN], top);
                            end
                            default: state_ff <= RME_ST_IDLE;
                        endcase
                    end
                end
                RME_ST_CHMASK, RME_ST_COPY: begin
                    i_ff <= i_ff + 14'h0001;
                    if (i_ff == top)
                        state_ff <= RME_ST_IDLE;
                end
                RME_ST_INS: begin
                    if (i_ff > amt_ff)
                        i_ff <= i_ff - 14'h0001;
                    else
                        state_ff <= RME_ST_IDLE;
                end
                RME_ST_DEL: begin
                    if (i_ff < top)
                        i_ff <= i_ff + 14'h0001;
                    else
                        state_ff <= RME_ST_IDLE;
                end
                RME_ST_REV: begin
                    if (lo_ff < hi_ff) begin
                        lo_ff <= lo_ff + 14'h0001;
                        hi_ff <= hi_ff - 14'h0001;
                    end else if (phase_ff == 2'h2) begin
                        state_ff <= RME_ST_IDLE;
                    end else begin
                        phase_ff <= phase_ff + 2'h1;
                        {lo_ff, hi_ff} <= rev_range(roll_up_ff, phase_ff + 2'h1, amt_ff,
                                                    top);
                    end
                end
                RME_ST_SUM: begin
                    sum_ff <= nxt_sum;
                    i_ff   <= i_ff + 14'h0001;
                    if (i_ff == top) begin
                        state_ff <= RME_ST_IDLE;
                        csum_ff  <= ctrl_ff[RME_CTRL_SMALL] ? (nxt_sum & RME_CSUM_SMALL)
                                                            : nxt_sum;
                    end
                end
                default: state_ff <= RME_ST_IDLE;
            endcase
        end
    end

    // Memory writes; whole words move so masks follow their data
    always_ff @(posedge pclk) begin
        case (state_ff)
            RME_ST_CHMASK: mem[i_ff].bmask[src_ff] <= 1'b1;
            RME_ST_COPY: begin
                mem[i_ff].data[dst_ff]  <= mem[i_ff].data[src_ff];
                mem[i_ff].bmask[dst_ff] <= mem[i_ff].bmask[src_ff];
            end
            RME_ST_INS: begin
                if (i_ff > amt_ff)
                    mem[i_ff] <= mem[i_ff - 14'h0001];
                else
                    mem[i_ff] <= '0;
            end
            RME_ST_DEL: begin
                if (i_ff < top)
                    mem[i_ff] <= mem[i_ff + 14'h0001];
                else
                    mem[i_ff] <= '0;
            end
            RME_ST_REV: begin
                if (lo_ff < hi_ff) begin
                    mem[lo_ff] <= mem[hi_ff];
                    mem[hi_ff] <= mem[lo_ff];
                end
            end
            RME_ST_IDLE: begin
                if (entry_wr) begin
                    mem[cur_addr_ff].data[cur_bit_ff]  <= pwdata[0];
                    mem[cur_addr_ff].bmask[cur_bit_ff] <= pwdata[1];
                    mem[cur_addr_ff].wmask             <= pwdata[2];
                end
            end
            default: ;
        endcase
    end

    // Cursor and auto-advance after data entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_addr_ff <= 14'h0000;
            cur_bit_ff  <= 5'h00;
        end else if (wr_fire && paddr == RME_OFF_CURSOR && idle) begin
            cur_addr_ff <= addr_ok(pwdata[13:0], top) ? pwdata[13:0] : cur_addr_ff;
            cur_bit_ff  <= pwdata[RME_CUR_BIT +: 5];
        end else if (entry_wr) begin
            case (rme_mode_t'(ctrl_ff[RME_CTRL_MODE +: 2]))
                RME_MODE_HOLD: cur_bit_ff <= cur_bit_ff;
                RME_MODE_HORIZ: begin
                    if (cur_bit_ff != 5'h1F) begin
                        cur_bit_ff <= cur_bit_ff + 5'h01;
                    end else if (cur_addr_ff < top) begin
                        cur_bit_ff  <= 5'h00;
                        cur_addr_ff <= cur_addr_ff + 14'h0001;
                    end
                end
                RME_MODE_VERT: begin
                    if (cur_addr_ff < top)
                        cur_addr_ff <= cur_addr_ff + 14'h0001;
                end
                default: cur_bit_ff <= cur_bit_ff;
            endcase
        end
    end

    // Compare against reference; masked positions never flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cmp_error_ff <= 1'b0;
        else
            cmp_error_ff <= cmp_valid & ~cmp_ref.wmask
                            & (|((cmp_data ^ cmp_ref.data) & ~cmp_ref.bmask));
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_range_flag: assert property (
        wr_fire && paddr == RME_OFF_ADDR && idle && pwdata[18:16] <= RME_SEL_RUP
        && pwdata[13:0] > top |=> err_ff)
        else $error("out-of-range entry not flagged");
    a_exit_clear: assert property (
        wr_fire && paddr == RME_OFF_CMD && pwdata[3:0] == RME_OP_EXIT
        |=> !err_ff && pend_op_ff == RME_OP_NONE)
        else $error("exit did not restore entry");
    a_no_confirm: assert property (
        idle && !start && !(wr_fire && paddr == RME_OFF_CMD) |=> idle)
        else $error("engine started without confirm");
    a_trig_min: assert property (
        ctrl_ff[RME_CTRL_RT] |-> trig_ff != 16'h0000)
        else $error("zero trigger delay in compare mode");
    a_cursor_hold: assert property (
        entry_wr && ctrl_ff[2:1] == RME_MODE_HOLD |=> $stable(cur_addr_ff) && $stable(cur_bit_ff))
        else $error("cursor moved in hold mode");
    a_cursor_vert: assert property (
        entry_wr && ctrl_ff[2:1] == RME_MODE_VERT && cur_addr_ff < top
        |=> cur_addr_ff == $past(cur_addr_ff) + 14'h0001 && $stable(cur_bit_ff))
        else $error("vertical advance wrong");
    a_cmp_masked: assert property (
        cmp_valid && cmp_ref.wmask |=> !cmp_error_ff)
        else $error("masked word flagged error");
    a_ins_zero: assert property (
        state_ff == RME_ST_INS && i_ff <= amt_ff |=> mem[$past(i_ff)] == '0 && idle)
        else $error("inserted word not zero");
    a_del_top: assert property (
        state_ff == RME_ST_DEL && i_ff == top |=> mem[$past(i_ff)] == '0 && idle)
        else $error("top word not zeroed on delete");
    a_chmask_set: assert property (
        state_ff == RME_ST_CHMASK |=> mem[$past(i_ff)].bmask[src_ff] == 1'b1)
        else $error("channel mask bit not set");
endmodule

// >>> dv/rme_panel.sv
// Front panel controller model: APB master with expected-read queue
`timescale 1ns/10ps
module rme_panel (
    input  wire logic        pclk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic [32:0] q[$];
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Issued only once the command and its channels are chosen
    task automatic go(input logic [31:0] d);
        xfer(1'b1, 8'h08, d);
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the reference memory editor
`timescale 1ns/10ps
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module testbench;
    import rme_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, busy, range_err;
    logic        cmp_valid = 1'b0;
    logic        cmp_error;
    logic        cv_d = 1'b0;
    logic        exp_cmp;
    logic [32:0] exp_rd;
    logic [7:0]  paddr;
    logic [13:0] cmp_addr = 14'h0000;
    logic [31:0] pwdata, prdata, rnd;
    logic [31:0] cmp_data = 32'h00000000;
    logic [0:0]  qc[$];
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #5 pclk = ~pclk;
    rme_panel panel (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    rme_editor DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_valid(cmp_valid), .cmp_addr(cmp_addr), .cmp_data(cmp_data),
        .cmp_error(cmp_error), .entry_range_error(range_err), .busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        panel.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        panel.q.push_back(e);
        panel.xfer(1'b0, a, 32'h00000000);
    endtask
    // Command, then confirm with random payload, then wait for idle
    task automatic run(input logic [31:0] c);
        wr(RME_OFF_CMD, c);
        rnd = lfsr(rnd);
        panel.go(rnd);
        @(posedge pclk);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge pclk);
    endtask
    task automatic cmp(input logic [13:0] a, input logic [31:0] d, input logic e);
        @(posedge pclk);
        qc.push_back(e);
        cmp_valid <= 1'b1;
        cmp_addr <= a;
        cmp_data <= d;
        @(posedge pclk);
        cmp_valid <= 1'b0;
    endtask
    always @(posedge pclk) begin
        // Pop once; the compare macro would otherwise pop again when printing
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp_rd = panel.q.pop_front();
            `CHK({pslverr, prdata}, exp_rd)
        end
        if (cv_d) begin
            exp_cmp = qc.pop_front();
            `CHK(cmp_error, exp_cmp)
        end
        cv_d <= cmp_valid;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        rnd = 32'd49;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wr(RME_OFF_CTRL, 32'h1);
        // Zero-filled lines give defined words at the low addresses
        for (int i = 0; i < 8; i++) begin
            wr(RME_OFF_ADDR, 32'h00010000);
            run(32'h3);
        end
        wr(RME_OFF_CURSOR, 32'h00050002);
        wr(RME_OFF_ENTRY, 32'h1);
        rd(RME_OFF_CURSOR, 33'h000050002);
        wr(RME_OFF_CURSOR, 32'h00060002);
        wr(RME_OFF_ENTRY, 32'h2);
        cmp(14'd2, 32'h60, 1'b0);
        cmp(14'd3, 32'h20, 1'b1);
        wr(RME_OFF_CTRL, 32'h3);
        wr(RME_OFF_CURSOR, 32'h001F0005);
        wr(RME_OFF_ENTRY, 32'h0);
        rd(RME_OFF_CURSOR, 33'h000000006);
        wr(RME_OFF_CTRL, 32'h5);
        wr(RME_OFF_ENTRY, 32'h0);
        rd(RME_OFF_CURSOR, 33'h000000007);
        wr(RME_OFF_ADDR, 32'h00010001);
        run(32'h3);
        cmp(14'd3, 32'h60, 1'b0);
        cmp(14'd2, 32'h0, 1'b0);
        wr(RME_OFF_ADDR, 32'h00020001);
        run(32'h4);
        cmp(14'd2, 32'h60, 1'b0);
        wr(RME_OFF_ADDR, 32'h00030002);
        run(32'h5);
        cmp(14'd4, 32'h60, 1'b0);
        wr(RME_OFF_ADDR, 32'h00040005);
        run(32'h6);
        cmp(14'd1023, 32'h60, 1'b0);
        wr(RME_OFF_ADDR, 32'h00030005);
        run(32'h5);
        cmp(14'd4, 32'h60, 1'b0);
        wr(RME_OFF_CMD, 32'h00090502);
        wr(RME_OFF_CMD, 32'h8);
        cmp(14'd4, 32'h260, 1'b1);
        run(32'h00090502);
        cmp(14'd4, 32'h260, 1'b0);
        run(32'h00000001);
        cmp(14'd1, 32'h1, 1'b0);
        wr(RME_OFF_ADDR, 32'h00010005);
        wr(RME_OFF_ADDR, 32'h00010400);
        rd(RME_OFF_STATUS, 33'h000000002);
        `CHK(range_err, 1'b1)
        wr(RME_OFF_CMD, 32'h8);
        rd(RME_OFF_ADDR, 33'h000010005);
        wr(RME_OFF_CTRL, 32'h9);
        rd(RME_OFF_TRIG, 33'h000000001);
        wr(RME_OFF_TRIG, 32'h0);
        rd(RME_OFF_TRIG, 33'h000000001);
        wr(RME_OFF_CURSOR, 32'h00030001);
        wr(RME_OFF_ENTRY, 32'h4);
        cmp(14'd1, 32'hFF, 1'b0);
        rd(8'h24, 33'h100000000);
        repeat (4) @(posedge pclk);
        print_verdict();
    end
endmodule
